// file: sim/bpw_pins.sv
`timescale 1ns/1ps
module bpw_pins (
   input  wire logic       clk,
   input  wire logic [7:0] drive,
   input  wire logic [7:0] oe_n,
   input  wire logic [7:0] pull,
   input  wire logic [7:0] ext_en,
   input  wire logic [7:0] ext_val,
   output logic      [7:0] level
);
   logic [7:0] flip = 8'h00;
   // floating pads wander so a stale level never passes
   always @(posedge clk) begin
      flip <= ~flip;
   end
   // resolve each pad from all parties
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (!oe_n[i]) level[i] = drive[i];
         else if (ext_en[i]) level[i] = ext_val[i];
         else if (pull[i]) level[i] = 1'b1;
         else level[i] = flip[i];
      end
   end
endmodule : bpw_pins

// file: sim/bpw_port_properties.sv
`timescale 1ns/1ps
module bpw_port_properties
   import bpw_pkg::*;
#(
   parameter logic [2:0] PULL_HIGH_OPTION = 3'h0,
   parameter bit         BUZZER_OPTION    = 1'b0
) (
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_write,
   input wire logic       reg_read,
   input wire logic [7:0] reg_rdata,
   input wire logic       buzzer_true,
   input wire logic [7:0] port_a_out,
   input wire logic [7:0] port_a_oe_n,
   input wire logic [7:0] port_b_out,
   input wire logic [7:0] port_b_oe_n,
   input wire logic [7:0] port_b_pull,
   input wire logic       ext_int
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ==========================================================
   // one write strobe to a given index
   sequence s_wr(logic [3:0] a);
      reg_write && reg_addr == a;
   endsequence
   property p_rst;
      disable iff (1'b0)
         !rst_n |=> port_a_oe_n == 8'hff && port_a_out == 8'hff;
   endproperty
   property p_wdat;
      s_wr(ADDR_PORT_A_DATA) |=> port_a_out == $past(reg_wdata);
   endproperty
   property p_wdir;
      s_wr(ADDR_PORT_A_DIRECTION) |=> port_a_oe_n == $past(reg_wdata);
   endproperty
   property p_hold;
      !(reg_write && reg_addr == ADDR_PORT_A_DATA) |=> $stable(port_a_out);
   endproperty
   property p_rd0;
      !reg_read |=> reg_rdata == 8'h00;
   endproperty
   property p_rdo;
      reg_read && reg_addr == ADDR_PORT_A_DATA && port_a_oe_n == 8'h00
         |=> reg_rdata == $past(port_a_out);
   endproperty
   property p_pull;
      // pull follows the direction register, which oe_n mirrors on port b
      $past(rst_n) |->
         port_b_pull == (PULL_HIGH_OPTION[1] ? port_b_oe_n : 8'h00);
   endproperty
   property p_buzz;
      BUZZER_OPTION |=>
         port_b_out[1:0] == {~$past(buzzer_true), $past(buzzer_true)};
   endproperty
   property p_eint;
      // ext_int follows the stored control bit one edge later
      s_wr(ADDR_SHARE_CTRL) ##1 !s_wr(ADDR_SHARE_CTRL)
         |=> ext_int == $past(reg_wdata[SHARE_EXT_INT_BIT], 2);
   endproperty
   a_rst:  assert property (p_rst)  else $error("ports not reset");
   a_wdat: assert property (p_wdat) else $error("latch not written");
   a_wdir: assert property (p_wdir) else $error("direction not set");
   a_hold: assert property (p_hold) else $error("latch changed");
   a_rd0:  assert property (p_rd0)  else $error("read data lingers");
   a_rdo:  assert property (p_rdo)  else $error("output read wrong");
   a_pull: assert property (p_pull) else $error("pull wrong");
   a_buzz: assert property (p_buzz) else $error("buzzer pair wrong");
   a_eint: assert property (p_eint) else $error("ext int wrong");
endmodule : bpw_port_properties

bind bpw_port bpw_port_properties #(
   .PULL_HIGH_OPTION(PULL_HIGH_OPTION), .BUZZER_OPTION(BUZZER_OPTION)
) u_props (
   .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
   .buzzer_true(buzzer_true), .port_a_out(port_a_out),
   .port_a_oe_n(port_a_oe_n), .port_b_out(port_b_out),
   .port_b_oe_n(port_b_oe_n),
   .port_b_pull(port_b_pull), .ext_int(ext_int)
);

// file: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import bpw_pkg::*;
   logic       clk, rst_n, reg_write, reg_read, halted, bz, tcm, seen_rd;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, a_in, a_o, a_oe, a_pu, b_in, b_o, b_oe;
   logic [7:0] b_pu, c_in, c_o, c_oe, c_pu, a_en, a_val, b_en, b_val, v, w;
   logic       wake_req, ext_int, tmr_in, irq;
   logic [7:0] exp_q[$];
   int         fail_count, checks_done, cycles, wakes, seed, wake_base;
   bpw_port #(.PULL_HIGH_OPTION(3'h5), .BUZZER_OPTION(1'b1)) dut (
      .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .halted(halted), .buzzer_true(bz), .timer_count_mode(tcm),
      .port_a_in(a_in), .port_a_out(a_o), .port_a_oe_n(a_oe),
      .port_a_pull(a_pu), .port_b_in(b_in), .port_b_out(b_o),
      .port_b_oe_n(b_oe), .port_b_pull(b_pu), .port_c_in(c_in),
      .port_c_out(c_o), .port_c_oe_n(c_oe), .port_c_pull(c_pu),
      .wake_req(wake_req), .ext_int(ext_int), .timer_event_in(tmr_in),
      .irq(irq));
   bpw_pins pa (.clk(clk), .drive(a_o), .oe_n(a_oe), .pull(a_pu),
      .ext_en(a_en), .ext_val(a_val), .level(a_in));
   bpw_pins pb (.clk(clk), .drive(b_o), .oe_n(b_oe), .pull(b_pu),
      .ext_en(b_en), .ext_val(b_val), .level(b_in));
   bpw_pins pc (.clk(clk), .drive(c_o), .oe_n(c_oe), .pull(c_pu),
      .ext_en(8'h00), .ext_val(8'h00), .level(c_in));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : stop_test
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask : idle
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
      @(posedge clk);
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      @(posedge clk);
   endtask : rd
   // ==========================================================
   // clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // read data watcher, wake pulse count and hang guard
   always @(posedge clk) begin
      if (seen_rd) check(reg_rdata, exp_q.pop_front());
      seen_rd <= reg_read;
      if (wake_req === 1'b1) wakes++;
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         stop_test();
      end
   end
   // main sequence
   initial begin
      {rst_n, reg_write, reg_read, halted, bz, tcm} = '0;
      {reg_addr, reg_wdata, a_en, a_val, b_en, b_val} = '0;
      seed = 74;
      idle(10);
      rst_n <= 1'b1;
      idle(1);
      check(a_o, PORT_RESET);
      for (int i = 1; i < 6; i += 2) rd(4'(i), PORT_RESET);
      rd(ADDR_PORT_C_DATA, 8'hff);
      check(b_pu, 8'h00);
      rd(4'hf, 8'h00);
      v = 8'($random(seed));
      a_en <= 8'hff;
      a_val <= v;
      idle(3);
      rd(ADDR_PORT_A_DATA, v);
      wr(ADDR_PORT_A_DIRECTION, 8'h00);
      check(a_o, 8'hff);
      w = 8'($random(seed));
      wr(ADDR_PORT_A_DATA, w);
      a_val <= ~w;
      idle(3);
      rd(ADDR_PORT_A_DATA, w);
      idle(20);
      check(a_o, w);
      wr(ADDR_PORT_B_DIRECTION, 8'hf0);
      b_en <= 8'hff;
      b_val <= v;
      wr(ADDR_PORT_B_DATA, w);
      bz <= 1'b1;
      tcm <= 1'b1;
      idle(3);
      rd(ADDR_PORT_B_DATA, (w & 8'h0f) | (v & 8'hf0));
      wr(ADDR_PORT_B_DATA, (w & 8'h0f) | (v & 8'hf0) | 8'h04);
      check(b_o & 8'h0c, (w | 8'h04) & 8'h0c);
      check(b_o & 8'h03, 8'h01);
      wr(ADDR_PORT_B_DIRECTION, 8'hff);
      idle(3);
      rd(ADDR_PORT_B_DATA, v);
      wr(ADDR_SHARE_CTRL, 8'h01);
      idle(1);
      check({7'h00, ext_int}, 8'h01);
      wr(ADDR_SHARE_CTRL, 8'h00);
      idle(1);
      check({7'h00, ext_int}, 8'h00);
      wr(ADDR_PORT_A_DIRECTION, 8'hff);
      a_val <= 8'hff;
      idle(3);
      wr(ADDR_WAKE_ENABLE, 8'h01);
      wr(ADDR_IRQ_MASK, 8'h01);
      wr(ADDR_IRQ_STATUS, 8'hff);
      wake_base = wakes;
      halted <= 1'b1;
      a_val <= 8'hfd;
      idle(8);
      check(8'(wakes - wake_base), 8'h00);
      a_val <= 8'hfc;
      idle(8);
      check(8'(wakes - wake_base), 8'h01);
      check({7'h00, irq}, 8'h01);
      wr(ADDR_IRQ_STATUS, 8'h01);
      check({7'h00, irq}, 8'h00);
      halted <= 1'b0;
      stop_test();
   end
endmodule : tb_top

// file: src/bpw_pkg.sv
package bpw_pkg;
   // ==========================================================
   // register indices on the plain register port
   localparam logic [3:0] ADDR_PORT_A_DATA      = 4'h0;
   localparam logic [3:0] ADDR_PORT_A_DIRECTION = 4'h1;
   localparam logic [3:0] ADDR_PORT_B_DATA      = 4'h2;
   localparam logic [3:0] ADDR_PORT_B_DIRECTION = 4'h3;
   localparam logic [3:0] ADDR_PORT_C_DATA      = 4'h4;
   localparam logic [3:0] ADDR_PORT_C_DIRECTION = 4'h5;
   localparam logic [3:0] ADDR_WAKE_ENABLE      = 4'h6;
   localparam logic [3:0] ADDR_IRQ_STATUS       = 4'h7;
   localparam logic [3:0] ADDR_IRQ_MASK         = 4'h8;
   localparam logic [3:0] ADDR_SHARE_CTRL       = 4'h9;
   // ==========================================================
   // reset values and field positions
   localparam logic [7:0] PORT_RESET            = 8'hff;
   localparam logic [7:0] WAKE_RESET            = 8'h00;
   localparam logic [7:0] IRQ_RESET             = 8'h00;
   localparam logic [7:0] SHARE_RESET           = 8'h00;
   localparam int         SHARE_EXT_INT_BIT     = 0;
   localparam int         SHARE_TMR_EXT_BIT     = 1;
   localparam int         IRQ_WAKE_BIT          = 0;
   localparam int         IRQ_EXT_INT_BIT       = 1;
   localparam int         IRQ_TMR_EDGE_BIT      = 2;

   typedef struct packed {
      logic [7:0] data;
      logic [7:0] direction;
   } bpw_port_type;

   typedef struct packed {
      bpw_port_type port_a;
      bpw_port_type port_b;
      bpw_port_type port_c;
      logic [7:0]   wake_enable;
      logic [7:0]   irq_status;
      logic [7:0]   irq_mask;
      logic [7:0]   share_ctrl;
      logic [7:0]   sync1_a;
      logic [7:0]   sync2_a;
      logic [7:0]   sync1_b;
      logic [7:0]   sync2_b;
      logic [7:0]   sync1_c;
      logic [7:0]   sync2_c;
      logic [7:0]   prev_a;
      logic [7:0]   prev_c;
      logic [7:0]   rdata;
      logic [7:0]   a_out;
      logic [7:0]   a_oe_n;
      logic [7:0]   b_out;
      logic [7:0]   b_oe_n;
      logic [7:0]   c_out;
      logic [7:0]   c_oe_n;
      logic [7:0]   pull_a;
      logic [7:0]   pull_b;
      logic [7:0]   pull_c;
      logic         wake_req;
      logic         irq;
      logic         ext_int;
      logic         timer_event_in;
   } bpw_state_type;
endpackage : bpw_pkg

// file: src/bpw_port.sv
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/1ps
// Behaviour
// - port read returns synchronised pin levels on input pins, the latch on output pins
// - output latch keeps written value until rewritten
// - pull-high option per port pulls every pin of that port whose direction bit is one
// - falling edge on wake-enabled port A input pin wakes halted core
// - each port A pin has its own wake enable bit
// - direction bit one makes pin input, read returns pin level
// - direction bit zero drives latch value push-pull
// - read of output pin returns latch, not pin level
// - inputs Schmitt; port A option selects plain inputs (PORT_A_SCHMITT is not used in this module; the input type is left to the pad)
// - buzzer pair drives port b pins zero/one only when outputs
// - port c pin zero is interrupt input only when enabled
// - port c pin one feeds timer only in count modes as input
// - reset sets all data and direction bits high
// - output without prior write drives high from reset latch
// - bit set/clear is read-modify-write of whole port byte
module bpw_port
   import bpw_pkg::*;
#(
   parameter logic [2:0] PULL_HIGH_OPTION = 3'h0,
   parameter bit         PORT_A_SCHMITT   = 1'b1,
   parameter bit         BUZZER_OPTION    = 1'b0
) (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic [3:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_write,
   input  wire logic       reg_read,
   output logic [7:0]      reg_rdata,
   input  wire logic       halted,
   input  wire logic       buzzer_true,
   input  wire logic       timer_count_mode,
   input  wire logic [7:0] port_a_in,
   output logic [7:0]      port_a_out,
   output logic [7:0]      port_a_oe_n,
   output logic [7:0]      port_a_pull,
   input  wire logic [7:0] port_b_in,
   output logic [7:0]      port_b_out,
   output logic [7:0]      port_b_oe_n,
   output logic [7:0]      port_b_pull,
   input  wire logic [7:0] port_c_in,
   output logic [7:0]      port_c_out,
   output logic [7:0]      port_c_oe_n,
   output logic [7:0]      port_c_pull,
   output logic            wake_req,
   output logic            ext_int,
   output logic            timer_event_in,
   output logic            irq
);
   // ==========================================================
   // state
   bpw_state_type r;
   bpw_state_type next_r;

   // pin view: outputs read the latch, inputs the pin
   function automatic logic [7:0] port_view(input bpw_port_type p,
                                            input logic [7:0] pins);
      port_view = (p.direction & pins) | (~p.direction & p.data);
   endfunction : port_view

   // write data for a port register
   function automatic logic [7:0] wr_byte(input logic [7:0] old,
                                          input logic       hit,
                                          input logic [7:0] wd);
      wr_byte = hit ? wd : old;
   endfunction : wr_byte

   logic [7:0] view_a;
   logic [7:0] view_b;
   logic [7:0] view_c;
   logic [7:0] fall_a;
   logic [7:0] ev;

   // ==========================================================
   // next state
   always_comb begin
      next_r = r;
      // two-stage synchronisers; schmitt choice is in the pad
      next_r.sync1_a = port_a_in;
      next_r.sync2_a = r.sync1_a;
      next_r.sync1_b = port_b_in;
      next_r.sync2_b = r.sync1_b;
      next_r.sync1_c = port_c_in;
      next_r.sync2_c = r.sync1_c;
      next_r.prev_a  = r.sync2_a;
      next_r.prev_c  = r.sync2_c;
      view_a = port_view(r.port_a, r.sync2_a);
      view_b = port_view(r.port_b, r.sync2_b);
      view_c = port_view(r.port_c, r.sync2_c);
      // register writes; bit ops arrive as whole-byte writes
      next_r.port_a.data = wr_byte(r.port_a.data,
         reg_write && reg_addr == ADDR_PORT_A_DATA, reg_wdata);
      next_r.port_a.direction = wr_byte(r.port_a.direction,
         reg_write && reg_addr == ADDR_PORT_A_DIRECTION, reg_wdata);
      next_r.port_b.data = wr_byte(r.port_b.data,
         reg_write && reg_addr == ADDR_PORT_B_DATA, reg_wdata);
      next_r.port_b.direction = wr_byte(r.port_b.direction,
         reg_write && reg_addr == ADDR_PORT_B_DIRECTION, reg_wdata);
      next_r.port_c.data = wr_byte(r.port_c.data,
         reg_write && reg_addr == ADDR_PORT_C_DATA, reg_wdata);
      next_r.port_c.direction = wr_byte(r.port_c.direction,
         reg_write && reg_addr == ADDR_PORT_C_DIRECTION, reg_wdata);
      next_r.wake_enable = wr_byte(r.wake_enable,
         reg_write && reg_addr == ADDR_WAKE_ENABLE, reg_wdata);
      next_r.irq_mask = wr_byte(r.irq_mask,
         reg_write && reg_addr == ADDR_IRQ_MASK, reg_wdata);
      next_r.share_ctrl = wr_byte(r.share_ctrl,
         reg_write && reg_addr == ADDR_SHARE_CTRL, reg_wdata);
      // falling edges on wake-enabled port a input pins
      fall_a = r.prev_a & ~r.sync2_a & r.wake_enable & r.port_a.direction;
      next_r.wake_req = halted && (|fall_a);
      // sticky events, set wins over write-one-clear
      ev = 8'h00;
      ev[IRQ_WAKE_BIT]    = |fall_a;
      ev[IRQ_EXT_INT_BIT] = r.ext_int && r.prev_c[0] && !r.sync2_c[0];
      ev[IRQ_TMR_EDGE_BIT] = r.timer_event_in
                             && (r.prev_c[1] != r.sync2_c[1]);
      next_r.irq_status = r.irq_status;
      if (reg_write && reg_addr == ADDR_IRQ_STATUS) begin
         next_r.irq_status = r.irq_status & ~reg_wdata;
      end
      next_r.irq_status = next_r.irq_status | ev;
      next_r.irq = |(next_r.irq_status & next_r.irq_mask);
      // shared pin functions
      next_r.ext_int = r.share_ctrl[SHARE_EXT_INT_BIT];
      next_r.timer_event_in = timer_count_mode
                              && r.share_ctrl[SHARE_TMR_EXT_BIT]
                              && r.port_c.direction[1];
      // pad drive: direction 0 drives latch, oe active low
      next_r.a_out  = next_r.port_a.data;
      next_r.a_oe_n = next_r.port_a.direction;
      next_r.b_out  = next_r.port_b.data;
      next_r.b_oe_n = next_r.port_b.direction;
      if (BUZZER_OPTION) begin
         next_r.b_out[0] = buzzer_true;
         next_r.b_out[1] = ~buzzer_true;
      end
      next_r.c_out  = next_r.port_c.data;
      next_r.c_oe_n = next_r.port_c.direction;
      if (next_r.share_ctrl[SHARE_EXT_INT_BIT]) begin
         next_r.c_oe_n[0] = 1'b1;
      end
      // pull-high per port on input pins only
      next_r.pull_a = {8{PULL_HIGH_OPTION[0]}} & next_r.port_a.direction;
      next_r.pull_b = {8{PULL_HIGH_OPTION[1]}} & next_r.port_b.direction;
      next_r.pull_c = {8{PULL_HIGH_OPTION[2]}} & next_r.port_c.direction;
      // read data, one cycle after the strobe
      next_r.rdata = 8'h00;
      if (reg_read) begin
         case (reg_addr)
            ADDR_PORT_A_DATA:      next_r.rdata = view_a;
            ADDR_PORT_A_DIRECTION: next_r.rdata = r.port_a.direction;
            ADDR_PORT_B_DATA:      next_r.rdata = view_b;
            ADDR_PORT_B_DIRECTION: next_r.rdata = r.port_b.direction;
            ADDR_PORT_C_DATA:      next_r.rdata = view_c;
            ADDR_PORT_C_DIRECTION: next_r.rdata = r.port_c.direction;
            ADDR_WAKE_ENABLE:      next_r.rdata = r.wake_enable;
            ADDR_IRQ_STATUS:       next_r.rdata = r.irq_status;
            ADDR_IRQ_MASK:         next_r.rdata = r.irq_mask;
            ADDR_SHARE_CTRL:       next_r.rdata = r.share_ctrl;
            default:               next_r.rdata = 8'h00;
         endcase
      end
   end

   // ==========================================================
   // registers
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         r                  <= '0;
         r.port_a.data      <= PORT_RESET;
         r.port_a.direction <= PORT_RESET;
         r.port_b.data      <= PORT_RESET;
         r.port_b.direction <= PORT_RESET;
         r.port_c.data      <= PORT_RESET;
         r.port_c.direction <= PORT_RESET;
         r.a_out            <= PORT_RESET;
         r.a_oe_n           <= PORT_RESET;
         r.b_out            <= PORT_RESET;
         r.b_oe_n           <= PORT_RESET;
         r.c_out            <= PORT_RESET;
         r.c_oe_n           <= PORT_RESET;
         r.wake_enable      <= WAKE_RESET;
         r.irq_status       <= IRQ_RESET;
         r.irq_mask         <= IRQ_RESET;
         r.share_ctrl       <= SHARE_RESET;
      end else begin
         r <= next_r;
      end
   end

   // ==========================================================
   // outputs straight from flops
   assign reg_rdata      = r.rdata;
   assign port_a_out     = r.a_out;
   assign port_a_oe_n    = r.a_oe_n;
   assign port_a_pull    = r.pull_a;
   assign port_b_out     = r.b_out;
   assign port_b_oe_n    = r.b_oe_n;
   assign port_b_pull    = r.pull_b;
   assign port_c_out     = r.c_out;
   assign port_c_oe_n    = r.c_oe_n;
   assign port_c_pull    = r.pull_c;
   assign wake_req       = r.wake_req;
   assign ext_int        = r.ext_int;
   assign timer_event_in = r.timer_event_in;
   assign irq            = r.irq;
endmodule : bpw_port
